// ==== inc/scan_pkg.sv ====
// Purpose: shared constants for the serial test port and its controller
// Assumes: three-bit instruction register, 32-bit id, 71-bit boundary chain
// Notes: id code value is arbitrary, not any maker's
package scan_pkg;
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_W = 71;
  localparam logic [2:0] INS_CAPTURE_HIZ = 3'h0;
  localparam logic [2:0] INS_IDENT = 3'h1;
  localparam logic [2:0] INS_SAMPLE_HIZ = 3'h2;
  localparam logic [2:0] INS_SAMPLE = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
  // arbitrary identification value, bit 0 set marks an id register
  localparam logic [31:0] ID_CODE = 32'h0a5a5001;
  localparam int RESET_ONES = 5;
  localparam int CLK_DIV = 5; // host system clocks per test clock half
  localparam int TCK_MAX_MHZ = 20;
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
    ST_PAUSE_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
    ST_EX1_IR, ST_PAUSE_IR, ST_EX2_IR, ST_UPD_IR
  } tap_state_t;
  function automatic tap_state_t tap_next(tap_state_t s, logic m);
    unique case (s)
      ST_RESET: tap_next = m ? ST_RESET : ST_IDLE;
      ST_IDLE: tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: tap_next = m ? ST_EX2_DR : ST_PAUSE_DR;
      ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: tap_next = m ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: tap_next = m ? ST_EX2_IR : ST_PAUSE_IR;
      ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_IDLE;
    endcase
  endfunction : tap_next
endpackage : scan_pkg

// ==== inc/scan_if.sv ====
// Purpose: serial test link between controller and memory test port
// Assumes: controller makes tck; tdo is three-signal, enable low drives
// Notes: wire level is not resolved; controller reads tdo_o whatever tdo_oe_n
`timescale 1ns/1ps
interface scan_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo_o;
  logic tdo_oe_n;
  modport port_end (input tck, input tms, input tdi,
    output tdo_o, output tdo_oe_n);
  modport ctrl_end (output tck, output tms, output tdi,
    input tdo_o, input tdo_oe_n);
endinterface : scan_if

// ==== rtl/scan_port.sv ====
// Purpose: memory test port: tap machine, instruction, id, bypass, chain
// Assumes: clk is the memory core clock, link logic runs on link tck
// Notes: observation only; never drives memory address or control
`timescale 1ns/1ps
// Summary of operation
// - identify capture loads 32-bit code
// - code is constant, shifted out
// - three-bit instruction register, eight codes
// - controller never loads reserved codes
// - scan never drives memory pins
// - shift instruction, apply at update
// - all-zeros acts as sample
// - all-zeros forces outputs high impedance
// - reset loads identify instruction
// - identify selects id register path
// - sample-hiz selects boundary chain
// - sample-hiz forces outputs high impedance
// - sample captures all pins
// - test clock at most 20 MHz
// - controller ignores captured clock bit
// - after capture shift boundary chain
// - preload never reaches the pins
// - bypass selects one-bit register
// - machine steps on tck by tms
// - five tms ones reset port
// - capture-ir loads 01 in low bits
// - sample rising, tdo falling edge
// - tdi into msb, tdo from lsb
module scan_port
  import scan_pkg::*;
#(
  parameter int CHAIN_W = BSR_W
) (
  // core clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // serial link
  scan_if.port_end lnk,
  // memory pins observed, core domain
  input wire logic [CHAIN_W-1:0] pin_obs,
  // high impedance request to memory outputs, core domain
  output logic out_hiz_r
);
  // link-domain state
  tap_state_t st_r;
  logic [IR_W-1:0] ir_sh_r;
  logic [IR_W-1:0] ir_r;
  logic [ID_W-1:0] id_r;
  logic byp_r;
  logic hiz_lk_r;
  // boundary chain bits, one flop per cell inside the generate loop
  logic [CHAIN_W-1:0] chain_bits;
  // core-domain copies
  logic [CHAIN_W-1:0] obs_s1_r;
  logic [CHAIN_W-1:0] obs_s2_r;
  logic hz_s1_r;
  // decoded state and path selects
  logic tdo_nxt;
  logic sh_dr;
  logic sh_ir;
  logic cap_dr;
  logic sel_id;
  logic sel_bsr;
  logic sel_byp;

  // pin snapshot resynchronised into core domain; capture only needs
  // a value stable over a core period, toggling pins may read either way
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      obs_s1_r <= '0;
      obs_s2_r <= '0;
    end else if (ce) begin
      obs_s1_r <= pin_obs;
      obs_s2_r <= obs_s1_r;
    end
  end

  // tap machine; power-up reset forces test-logic-reset; tms high five
  // edges reaches reset from any state by construction
  always_ff @(posedge lnk.tck or posedge rst) begin
    if (rst) st_r <= ST_RESET;
    else if (ce) st_r <= tap_next(st_r, lnk.tms);
  end

  // state decode shared by all registers
  assign sh_dr = (st_r == ST_SH_DR);
  assign sh_ir = (st_r == ST_SH_IR);
  assign cap_dr = (st_r == ST_CAP_DR);

  // path selects from the active instruction; the all-zeros code is
  // handled as sample, reserved codes fall back to the bypass cell so
  // a stray load still leaves a one-bit path on the board
  assign sel_id = (ir_r == INS_IDENT);
  assign sel_bsr = (ir_r == INS_SAMPLE) || (ir_r == INS_SAMPLE_HIZ) ||
    (ir_r == INS_CAPTURE_HIZ);
  assign sel_byp = !sel_id && !sel_bsr;

  // instruction shift stage and active instruction; the active code only
  // moves at update or in test-logic-reset, so shifting never disturbs the running instruction
  always_ff @(posedge lnk.tck or posedge rst) begin
    if (rst) begin
      ir_sh_r <= INS_IDENT;
      ir_r <= INS_IDENT;
    end else if (ce) begin
      if (st_r == ST_RESET) ir_r <= INS_IDENT;
      else if (st_r == ST_UPD_IR) ir_r <= ir_sh_r;
      if (st_r == ST_CAP_IR)
        ir_sh_r <= {{(IR_W-2){1'b0}}, IR_CAPTURE_PAT};
      else if (sh_ir) ir_sh_r <= {lnk.tdi, ir_sh_r[IR_W-1:1]};
    end
  end

  // hiz level kept as a flop beside the instruction, so the core
  // synchroniser never sees a decode glitch while instruction bits move
  always_ff @(posedge lnk.tck or posedge rst) begin
    if (rst) hiz_lk_r <= 1'b0;
    else if (ce) begin
      if (st_r == ST_RESET) hiz_lk_r <= 1'b0;
      else if (st_r == ST_UPD_IR)
        hiz_lk_r <= (ir_sh_r == INS_CAPTURE_HIZ) ||
          (ir_sh_r == INS_SAMPLE_HIZ);
    end
  end

  // identification register: fixed code at capture, then shifts
  always_ff @(posedge lnk.tck or posedge rst) begin
    if (rst) id_r <= '0;
    else if (ce && sel_id) begin
      if (cap_dr) id_r <= ID_CODE;
      else if (sh_dr) id_r <= {lnk.tdi, id_r[ID_W-1:1]};
    end
  end

  // bypass cell: captures low, then passes tdi through one flop
  always_ff @(posedge lnk.tck or posedge rst) begin
    if (rst) byp_r <= 1'b0;
    else if (ce && sel_byp) begin
      if (cap_dr) byp_r <= 1'b0;
      else if (sh_dr) byp_r <= lnk.tdi;
    end
  end

  // boundary chain, one cell per bit; capture from the core-side copy,
  // shift towards bit 0; cells have no update latch, so a preload
  // pattern shifted in can never reach a pin
  for (genvar b = 0; b < CHAIN_W; b++) begin : g_cell
    logic cell_r;
    logic cell_in;
    if (b == CHAIN_W - 1) begin : g_top
      assign cell_in = lnk.tdi;
    end else begin : g_mid
      assign cell_in = chain_bits[b+1];
    end
    always_ff @(posedge lnk.tck or posedge rst) begin
      if (rst) cell_r <= 1'b0;
      else if (ce && sel_bsr) begin
        if (cap_dr) cell_r <= obs_s2_r[b];
        else if (sh_dr) cell_r <= cell_in;
      end
    end
    assign chain_bits[b] = cell_r;
  end

  // output mux from lsb of the selected register
  always_comb begin
    tdo_nxt = byp_r;
    if (sh_ir) tdo_nxt = ir_sh_r[0];
    else if (sel_id) tdo_nxt = id_r[0];
    else if (sel_bsr) tdo_nxt = chain_bits[0];
  end

  // tdo changes on falling tck, driven only during shift states; half a
  // period of margin before the controller samples at the next rise
  always_ff @(negedge lnk.tck or posedge rst) begin
    if (rst) begin
      lnk.tdo_o <= 1'b0;
      lnk.tdo_oe_n <= 1'b1;
    end else if (ce) begin
      lnk.tdo_o <= tdo_nxt;
      lnk.tdo_oe_n <= !(sh_dr || sh_ir);
    end
  end

  // hiz request level, crossed to core domain by two flops; only the
  // output enables of the memory are touched, never address or control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hz_s1_r <= 1'b0;
      out_hiz_r <= 1'b0;
    end else if (ce) begin
      hz_s1_r <= hiz_lk_r;
      out_hiz_r <= hz_s1_r;
    end
  end
endmodule : scan_port

// ==== rtl/scan_ctrl.sv ====
// Purpose: board-side controller: makes tck, runs one tck cycle per request
// Assumes: request is a tms/tdi bit pair per tck cycle from user logic
// Notes: tck is divided from clk, so no second domain on this end
`timescale 1ns/1ps
module scan_ctrl
  import scan_pkg::*;
#(
  parameter int DIV = CLK_DIV
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // bit request: one tck cycle with given tms and tdi
  input wire logic bit_valid,
  input wire logic bit_tms,
  input wire logic bit_tdi,
  output logic bit_ready_r,
  // bit answer: tdo sampled on the rising edge of that cycle
  output logic rsp_valid_r,
  output logic rsp_tdo_r,
  // link
  scan_if.ctrl_end lnk
);
  logic [7:0] div_r;
  logic busy_r, tck_r, tms_r, tdi_r;
  logic tdo_s1_r, tdo_s2_r;
  logic half_end;

  assign half_end = (div_r == 8'(DIV - 1)); // DIV 5 gives 10 MHz
  assign lnk.tck = tck_r;
  assign lnk.tms = tms_r;
  assign lnk.tdi = tdi_r;

  // tdo from another edge; two flops before use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tdo_s1_r <= 1'b0;
      tdo_s2_r <= 1'b0;
    end else if (ce) begin
      tdo_s1_r <= lnk.tdo_o;
      tdo_s2_r <= tdo_s1_r;
    end
  end

  // one tck period per accepted bit: low half then high half;
  // tms/tdi set at start of low half so they are stable at the rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= '0;
      busy_r <= 1'b0;
      tck_r <= 1'b0;
      tms_r <= 1'b1;
      tdi_r <= 1'b1;
      bit_ready_r <= 1'b1;
      rsp_valid_r <= 1'b0;
      rsp_tdo_r <= 1'b0;
    end else if (ce) begin
      rsp_valid_r <= 1'b0;
      if (!busy_r) begin
        if (bit_valid && bit_ready_r) begin
          busy_r <= 1'b1;
          bit_ready_r <= 1'b0;
          tms_r <= bit_tms;
          tdi_r <= bit_tdi;
          div_r <= '0;
        end
      end else if (half_end) begin
        div_r <= '0;
        if (!tck_r) begin
          tck_r <= 1'b1;
          rsp_tdo_r <= tdo_s2_r; // tdo settled since falling edge
        end else begin
          tck_r <= 1'b0;
          busy_r <= 1'b0;
          bit_ready_r <= 1'b1;
          rsp_valid_r <= 1'b1; // caller discards clock bit
        end
      end else begin
        div_r <= div_r + 8'h01;
      end
    end
  end
endmodule : scan_ctrl

// ==== testbench/scan_props.sv ====
// Purpose: link checks between controller and memory test port
// Assumes: controller divider DIV is 2, so tck high is 2 clk long, low at least 2
// Notes: watches only the link wires, state tracked from tms
`timescale 1ns/1ps
module scan_props
  import scan_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo_o,
  input wire logic tdo_oe_n
);
  tap_state_t st_r;
  logic [2:0] ones_r;
  // own view of the machine, so shift windows are known
  always_ff @(posedge tck or posedge rst) begin
    if (rst) st_r <= ST_RESET;
    else st_r <= tap_next(st_r, tms);
  end
  // run of tms ones, saturates at five
  always_ff @(posedge tck or posedge rst) begin
    if (rst) ones_r <= 3'h0;
    else ones_r <= !tms ? 3'h0 : (ones_r == 3'h5 ? 3'h5 : ones_r + 3'h1);
  end
  a_tdo_on_fall: assert property (@(posedge clk) disable iff (rst)
    !$fell(tck) |-> $stable(tdo_o)) else $error("tdo moved off a fall");
  a_oe_on_fall: assert property (@(posedge clk) disable iff (rst)
    !$fell(tck) |-> $stable(tdo_oe_n)) else $error("enable moved off a fall");
  a_oe_in_shift: assert property (@(posedge tck) disable iff (rst)
    tdo_oe_n == !(st_r inside {ST_SH_DR, ST_SH_IR}))
    else $error("tdo driven outside shift");
  a_ir_capture: assert property (@(posedge tck) disable iff (rst)
    st_r == ST_CAP_IR && !tms |=> tdo_o ##1 !tdo_o)
    else $error("instruction capture not 01");
  a_five_ones: assert property (@(posedge tck) disable iff (rst)
    ones_r == 3'h5 |-> tdo_oe_n) else $error("five ones did not reset");
  a_tck_high: assert property (@(posedge clk) disable iff (rst)
    $rose(tck) |-> tck [*2] ##1 !tck) else $error("tck high time wrong");
  a_tck_low: assert property (@(posedge clk) disable iff (rst)
    $fell(tck) |-> !tck [*2]) else $error("tck low time short");
  a_drive_steady: assert property (@(posedge clk) disable iff (rst)
    tck |-> $stable({tms, tdi})) else $error("tms or tdi moved, tck high");
  // main scenarios reached
  c_upd_ir: cover property (@(posedge tck) st_r == ST_UPD_IR);
  c_dr_shift: cover property (@(posedge tck) st_r == ST_SH_DR);
  c_ones: cover property (@(posedge tck) ones_r == 3'h5);
endmodule : scan_props

// ==== testbench/sram_jtag_instruction_logic_tb.sv ====
// Purpose: bench joining controller and test port over the link
// Assumes: DIV 2, chain 71, controller makes tck from clk
// Notes: only defined instruction codes are ever loaded
`timescale 1ns/1ps
module sram_jtag_instruction_logic_tb;
  import scan_pkg::*;
  typedef struct {logic [2:0] code; logic hiz; int len;} row_t;
  logic clk, rst, bit_valid, bit_tms, bit_tdi, bit_ready_r;
  logic rsp_valid_r, rsp_tdo_r, out_hiz_r, q;
  logic [70:0] pin_obs;
  logic [79:0] o, e;
  int n_errors, num_checks;
  row_t rows[8] = '{'{3'h0, 1'b1, 71}, '{3'h1, 1'b0, 32},
    '{3'h2, 1'b1, 71}, '{3'h1, 1'b0, 32}, '{3'h4, 1'b0, 71},
    '{3'h4, 1'b0, 71}, '{3'h0, 1'b1, 71}, '{3'h7, 1'b0, 1}};
  scan_if scan_if_i ();
  scan_port scan_port_i (.clk(clk), .rst(rst), .ce(1'b1), .lnk(scan_if_i),
    .pin_obs(pin_obs), .out_hiz_r(out_hiz_r));
  scan_ctrl #(.DIV(2)) scan_ctrl_i (.clk(clk), .rst(rst), .ce(1'b1),
    .bit_valid(bit_valid), .bit_tms(bit_tms), .bit_tdi(bit_tdi),
    .bit_ready_r(bit_ready_r), .rsp_valid_r(rsp_valid_r),
    .rsp_tdo_r(rsp_tdo_r), .lnk(scan_if_i));
  scan_props scan_props_i (.clk(clk), .rst(rst), .tck(scan_if_i.tck),
    .tms(scan_if_i.tms), .tdi(scan_if_i.tdi), .tdo_o(scan_if_i.tdo_o),
    .tdo_oe_n(scan_if_i.tdo_oe_n));
  task automatic test_done();
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic cmp(string nm, logic [79:0] x, logic [79:0] g);
    num_checks++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : cmp
  // one tck cycle; bounded waits, the watchdog catches the rest
  task automatic bit1(logic m, logic d, output logic r);
    int t = 0;
    @(negedge clk);
    {bit_valid, bit_tms, bit_tdi} = {1'b1, m, d};
    while (bit_ready_r !== 1'b1 && t++ < 50) @(negedge clk);
    @(negedge clk);
    bit_valid = 1'b0;
    do @(negedge clk); while (rsp_valid_r !== 1'b1 && t++ < 90);
    r = rsp_tdo_r;
  endtask : bit1
  // idle to idle through one register scan, lsb out first
  task automatic scan(logic ir, int n, logic [79:0] din,
    output logic [79:0] d);
    logic r;
    d = '0;
    bit1(1'b1, 1'b0, r);
    if (ir) bit1(1'b1, 1'b0, r);
    bit1(1'b0, 1'b0, r);
    bit1(1'b0, 1'b0, r);
    for (int i = 0; i < n; i++) begin
      bit1(i == n - 1, din[i], r);
      d[i] = r;
    end
    bit1(1'b1, 1'b0, r);
    bit1(1'b0, 1'b0, r);
  endtask : scan
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, well above the run's length
  initial begin
    #300000;
    n_errors++;
    test_done();
  end
  initial begin
    {rst, bit_valid, bit_tms, bit_tdi} = 4'hb;
    {n_errors, num_checks} = '0;
    pin_obs = {7'h5a, 64'h0123456789abcdef};
    repeat (5) @(negedge clk);
    rst = 1'b0;
    bit1(1'b0, 1'b0, q);
    scan(1'b0, 40, 80'ha5, o);
    cmp("id_after_reset", ID_CODE, o[31:0]);
    cmp("id_tdi_path", 8'ha5, o[39:32]);
    foreach (rows[i]) begin
      scan(1'b1, 6, {rows[i].code, 3'h5}, o);
      cmp("ir_capture", 2'h1, o[1:0]);
      cmp("ir_length", 3'h5, o[5:3]);
      cmp("hiz", rows[i].hiz, out_hiz_r);
      e = rows[i].len == 71 ? 80'(pin_obs) :
        80'(rows[i].len == 32 ? ID_CODE : 0);
      scan(1'b0, rows[i].len + 8, 80'ha5, o);
      cmp("dr_capture", e, o & ((80'h1 << rows[i].len) - 80'h1));
      e = (o >> rows[i].len) & 80'hff;
      cmp("dr_path", 80'ha5, e);
    end
    // five ones from sample-hiz: identify again, outputs released
    scan(1'b1, 6, {3'h2, 3'h5}, o);
    repeat (5) bit1(1'b1, 1'b0, q);
    repeat (6) @(negedge clk);
    cmp("hiz_after_ones", 1'b0, out_hiz_r);
    bit1(1'b0, 1'b0, q);
    scan(1'b0, 32, 80'h0, o);
    cmp("id_after_ones", ID_CODE, o[31:0]);
    test_done();
  end
endmodule : sram_jtag_instruction_logic_tb
